// >>> e1ras_top.sv
// E1 receive alignment status bank: timers, alignment flags and captured words
`timescale 1ns/1ps

// Notes on behaviour
// - Sync bit 7: basic frame loss
// - Sync bit 6: signalling multiframe loss
// - Sync bit 5: CRC-4 multiframe loss
// - Sync bits 4,3: last E1, E2 bits
// - Reframe flag if no CRC-4 in 8 ms
// - Persistence flag holds 8 ms past loss
// - Sync bit 0: CRC-4 interworking status
// - Alignment word bit 7: first FAS bit
// - Alignment word bits 6-0: FAS bits 2-8
// - Half-second toggle every 0.5 s
// - One-second toggle every second, in step
// - CRC interval bit high 8 ms, falls
// - Remote-error interval bit high 8 ms, falls
// - Long timer bit flips at 400 ms expiry
// - Short timer bit flips at 8 ms expiry
// - Alignment indicator: 2 ms toggle or multiframe
// - Non-alignment bit 7: first NFAS bit
// - Non-alignment bit 6: frame type bit
// - Non-alignment bit 5: remote alarm
// - Non-alignment bits 4-0: national bits
// - TS16 word bits 7-4: alignment nibble
// - TS16 word register at 14H
module e1ras_top #(
  parameter int unsigned MS_CYCLES = e1ras_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Register port
  input wire e1ras_pkg::e1ras_bus_req_t i_bus,
  output logic [7:0] o_rd_data,
  // Framer alignment state
  input wire e1ras_pkg::e1ras_align_t i_align,
  input wire logic i_crc_mf_start,
  input wire logic i_ebit_valid,
  input wire logic [1:0] i_ebits,
  // Received overhead words
  input wire e1ras_pkg::e1ras_rx_word_t i_fas,
  input wire e1ras_pkg::e1ras_rx_word_t i_nfas,
  input wire e1ras_pkg::e1ras_rx_word_t i_ts16,
  // Status back to the framer
  output logic o_alignment_loss_persistence,
  output logic o_checksum_reframe_flag,
  output logic o_checksum_interworking
);
  import e1ras_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] ms_div;
  logic ms_tick;
  logic [9:0] ms_in_sec;
  logic half_second_toggle;
  logic one_second_toggle;
  logic interval_timer;
  logic frame_loss;
  logic frame_loss_d;
  logic signalling_multiframe_loss;
  logic checksum_multiframe_loss;
  logic remote_error_bit_one;
  logic remote_error_bit_two;
  logic [3:0] persist_cnt;
  logic alignment_loss_persistence;
  e1ras_state_t state;
  e1ras_state_t next_state;
  logic [3:0] short_cnt;
  logic [8:0] long_cnt;
  logic short_expire;
  logic long_expire;
  logic long_alignment_timer;
  logic short_alignment_timer;
  logic checksum_reframe_flag;
  logic checksum_interworking;
  logic [1:0] checksum_alignment_indicator_cnt;
  logic checksum_alignment_indicator;
  logic [7:0] fas_word;
  logic [7:0] nfas_word;
  logic [7:0] ts16_word;
  logic frame_acquired;
  logic [7:0] next_rd_data;

  // ---------------------------------------------------------------
  // Millisecond time base
  // ---------------------------------------------------------------
  // One shared tick keeps every timer in step at the cost of up to
  // one millisecond of phase error on timers started by events.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_div <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_div == MS_CYCLES - 32'h1) begin
      ms_div <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_div <= ms_div + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_in_sec <= 10'h0;
    end else if (ms_tick) begin
      if (ms_in_sec == SEC_MS - 10'h1) begin
        ms_in_sec <= 10'h0;
      end else begin
        ms_in_sec <= ms_in_sec + 10'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Free-running second timers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      half_second_toggle <= 1'b0;
      one_second_toggle <= 1'b0;
    end else if (ms_tick) begin
      if (ms_in_sec == HALF_SEC_MS - 10'h1 || ms_in_sec == SEC_MS - 10'h1) begin
        half_second_toggle <= ~half_second_toggle;
      end
      if (ms_in_sec == SEC_MS - 10'h1) begin
        one_second_toggle <= ~one_second_toggle;
      end
    end
  end

  // Both accumulation intervals end on the second boundary
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      interval_timer <= 1'b0;
    end else if (ms_tick) begin
      interval_timer <= (ms_in_sec >= SEC_MS - INTERVAL_HIGH_MS - 10'h1) &&
                        (ms_in_sec != SEC_MS - 10'h1);
    end
  end

  // ---------------------------------------------------------------
  // Alignment state capture
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_loss <= RST_LOSS;
      frame_loss_d <= RST_LOSS;
      signalling_multiframe_loss <= RST_LOSS;
      checksum_multiframe_loss <= RST_LOSS;
    end else begin
      frame_loss <= i_align.frame_loss;
      frame_loss_d <= frame_loss;
      signalling_multiframe_loss <= i_align.signalling_multiframe_loss;
      checksum_multiframe_loss <= i_align.checksum_multiframe_loss;
    end
  end

  assign frame_acquired = frame_loss_d && !frame_loss;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      remote_error_bit_one <= 1'b0;
      remote_error_bit_two <= 1'b0;
    end else if (i_ebit_valid) begin
      remote_error_bit_one <= i_ebits[1];
      remote_error_bit_two <= i_ebits[0];
    end
  end

  // ---------------------------------------------------------------
  // Persistence of basic frame loss
  // ---------------------------------------------------------------
  // One extra tick of hold guarantees at least the full 8 ms.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      persist_cnt <= 4'h0;
      alignment_loss_persistence <= RST_LOSS;
    end else begin
      if (i_align.frame_loss) begin
        persist_cnt <= PERSIST_MS + 4'h1;
      end else if (ms_tick && persist_cnt != 4'h0) begin
        persist_cnt <= persist_cnt - 4'h1;
      end
      alignment_loss_persistence <= i_align.frame_loss || (persist_cnt != 4'h0);
    end
  end

  // ---------------------------------------------------------------
  // CRC-4 multiframe search timers
  // ---------------------------------------------------------------
  assign short_expire = (state == ST_SEARCH) && ms_tick && (short_cnt == SHORT_TIMER_MS - 4'h1);
  assign long_expire = (state == ST_SEARCH) && ms_tick && (long_cnt == LONG_TIMER_MS - 9'h1);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_acquired && checksum_multiframe_loss) begin
          next_state = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (frame_loss || !checksum_multiframe_loss) begin
          next_state = ST_IDLE;
        end else if (long_expire) begin
          next_state = ST_FAIL;
        end
      end
      ST_FAIL: begin
        if (frame_loss || !checksum_multiframe_loss) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      short_cnt <= 4'h0;
      long_cnt <= 9'h0;
    end else if (state != ST_SEARCH) begin
      short_cnt <= 4'hf;
      long_cnt <= 9'h0;
    end else if (ms_tick) begin
      // Starts one below zero: first expiry 8 to 9 ms, then reloads
      short_cnt <= short_expire ? 4'h0 : short_cnt + 4'h1;
      long_cnt <= long_cnt + 9'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      short_alignment_timer <= 1'b0;
      long_alignment_timer <= 1'b0;
    end else begin
      if (short_expire) begin
        short_alignment_timer <= ~short_alignment_timer;
      end
      if (long_expire) begin
        long_alignment_timer <= ~long_alignment_timer;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      checksum_reframe_flag <= 1'b0;
    end else if (short_expire) begin
      // set on timeout, wins over clear
      checksum_reframe_flag <= 1'b1;
    end else if (!checksum_multiframe_loss) begin
      checksum_reframe_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      checksum_interworking <= RST_INTERWORKING;
    end else if (long_expire) begin
      checksum_interworking <= 1'b0;
    end else if (!checksum_multiframe_loss) begin
      checksum_interworking <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // CRC-4 alignment indicator
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      checksum_alignment_indicator_cnt <= 2'h0;
      checksum_alignment_indicator <= 1'b0;
    end else if (checksum_multiframe_loss) begin
      // free 2 ms toggle while searching
      if (ms_tick) begin
        if (checksum_alignment_indicator_cnt == CHECKSUM_ALIGNMENT_INDICATOR_MS - 2'h1) begin
          checksum_alignment_indicator_cnt <= 2'h0;
          checksum_alignment_indicator <= ~checksum_alignment_indicator;
        end else begin
          checksum_alignment_indicator_cnt <= checksum_alignment_indicator_cnt + 2'h1;
        end
      end
    end else begin
      checksum_alignment_indicator_cnt <= 2'h0;
      if (i_crc_mf_start) begin
        checksum_alignment_indicator <= ~checksum_alignment_indicator;
      end
    end
  end

  // ---------------------------------------------------------------
  // Received overhead words
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fas_word <= RST_WORD;
    end else if (i_fas.valid) begin
      // whole FAS byte, first bit at 7
      fas_word <= i_fas.word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nfas_word <= RST_WORD;
    end else if (i_nfas.valid) begin
      nfas_word <= i_nfas.word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ts16_word <= RST_WORD;
    end else if (i_ts16.valid) begin
      ts16_word <= i_ts16.word;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Write strobes are ignored: every register here is read-only.
  always_comb begin
    next_rd_data = 8'h00;
    case (i_bus.addr)
      ADDR_SYNC_STATUS: begin
        next_rd_data = {frame_loss, signalling_multiframe_loss, checksum_multiframe_loss,
                        remote_error_bit_one, remote_error_bit_two, checksum_reframe_flag,
                        alignment_loss_persistence, checksum_interworking};
      end
      ADDR_ALIGN_WORD: begin
        next_rd_data = fas_word;
      end
      ADDR_TIMER_STATUS: begin
        next_rd_data = {half_second_toggle, one_second_toggle, interval_timer, interval_timer,
                        long_alignment_timer, short_alignment_timer,
                        checksum_alignment_indicator, 1'b0};
      end
      ADDR_NON_ALIGN_WORD: begin
        next_rd_data = nfas_word;
      end
      ADDR_TS16_WORD: begin
        next_rd_data = ts16_word;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_bus.rd ? next_rd_data : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  assign o_alignment_loss_persistence = alignment_loss_persistence;
  assign o_checksum_reframe_flag = checksum_reframe_flag;
  assign o_checksum_interworking = checksum_interworking;

endmodule

// >>> e1ras_pkg.sv
// Shared constants and types for the E1 receive alignment status bank
package e1ras_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Timer lengths in milliseconds
  // ---------------------------------------------------------------
  localparam logic [9:0] HALF_SEC_MS = 10'h1f4;
  localparam logic [9:0] SEC_MS = 10'h3e8;
  localparam logic [9:0] INTERVAL_HIGH_MS = 10'h008;
  localparam logic [3:0] PERSIST_MS = 4'h8;
  localparam logic [3:0] SHORT_TIMER_MS = 4'h8;
  localparam logic [8:0] LONG_TIMER_MS = 9'h190;
  localparam logic [1:0] CHECKSUM_ALIGNMENT_INDICATOR_MS = 2'h2;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ALIGN_WORD = 8'h11;
  localparam logic [7:0] ADDR_TIMER_STATUS = 8'h12;
  localparam logic [7:0] ADDR_NON_ALIGN_WORD = 8'h13;
  localparam logic [7:0] ADDR_TS16_WORD = 8'h14;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_WORD = 8'h00;
  localparam logic RST_LOSS = 1'b1;
  localparam logic RST_INTERWORKING = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } e1ras_bus_req_t;

  typedef struct packed {
    logic frame_loss;
    logic signalling_multiframe_loss;
    logic checksum_multiframe_loss;
  } e1ras_align_t;

  typedef struct packed {
    logic valid;
    logic [7:0] word;
  } e1ras_rx_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEARCH = 3'b010,
    ST_FAIL = 3'b100
  } e1ras_state_t;

endpackage

// >>> e1ras_checker_sva.sv
// Concurrent checks on the E1 receive alignment status bank ports
`timescale 1ns/1ps
module e1ras_checker #(
  parameter int unsigned MS_CYCLES = e1ras_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Register port and framer state
  input wire e1ras_pkg::e1ras_bus_req_t i_bus,
  input wire logic [7:0] o_rd_data,
  input wire e1ras_pkg::e1ras_align_t i_align,
  // Status outputs
  input wire logic o_alignment_loss_persistence,
  input wire logic o_checksum_reframe_flag,
  input wire logic o_checksum_interworking
);
  import e1ras_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  int low_cnt;
  int srch;
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  // Saturate so long runs never wrap back into a checked window
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) low_cnt <= 0;
    else if (i_align.frame_loss) low_cnt <= 0;
    else if (low_cnt < 20 * MS_CYCLES) low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) srch <= 0;
    else if (i_align.frame_loss || !i_align.checksum_multiframe_loss) srch <= 0;
    else if (srch < 20 * MS_CYCLES) srch <= srch + 1;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence
  property p_rd_idle; !i_bus.rd |=> o_rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; i_bus.rd && i_bus.addr > ADDR_TS16_WORD |=> o_rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sync_low;
    s_rd(ADDR_SYNC_STATUS) |=> o_rd_data[2:0] == {$past(o_checksum_reframe_flag),
      $past(o_alignment_loss_persistence), $past(o_checksum_interworking)};
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync low bits wrong");
  property p_sync_loss; s_rd(ADDR_SYNC_STATUS) |=> o_rd_data[7:5] == $past(i_align, 2); endproperty
  a_sync_loss: assert property (p_sync_loss) else $error("sync loss bits wrong");
  property p_persist_on; i_align.frame_loss |=> o_alignment_loss_persistence; endproperty
  a_persist_on: assert property (p_persist_on) else $error("persistence not raised");
  property p_persist_hold;
    low_cnt > 0 && low_cnt <= 8 * MS_CYCLES |-> o_alignment_loss_persistence;
  endproperty
  a_persist_hold: assert property (p_persist_hold) else $error("persistence dropped early");
  property p_persist_end; low_cnt > 10 * MS_CYCLES |-> !o_alignment_loss_persistence; endproperty
  a_persist_end: assert property (p_persist_end) else $error("persistence held too long");
  property p_reframe_early; $rose(o_checksum_reframe_flag) |-> srch >= 8 * MS_CYCLES; endproperty
  a_reframe_early: assert property (p_reframe_early) else $error("reframe set early");
  property p_reframe_late; srch == 10 * MS_CYCLES |-> o_checksum_reframe_flag; endproperty
  a_reframe_late: assert property (p_reframe_late) else $error("reframe not set");
  property p_align_clear;
    !i_align.checksum_multiframe_loss [*3] |-> !o_checksum_reframe_flag && o_checksum_interworking;
  endproperty
  a_align_clear: assert property (p_align_clear) else $error("alignment did not clear");
endmodule
bind e1ras_top e1ras_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.i_core_clk(i_core_clk),
  .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rd_data(o_rd_data), .i_align(i_align),
  .o_alignment_loss_persistence(o_alignment_loss_persistence),
  .o_checksum_reframe_flag(o_checksum_reframe_flag), .o_checksum_interworking(o_checksum_interworking));

// >>> e1ras_line_model.sv
// Behavioural model of the received E1 line overhead feeding the bank
`timescale 1ns/1ps
module e1ras_line_model (
  // Clock
  input wire logic i_core_clk,
  // Overhead seen on the line
  output e1ras_pkg::e1ras_rx_word_t o_fas,
  output e1ras_pkg::e1ras_rx_word_t o_nfas,
  output e1ras_pkg::e1ras_rx_word_t o_ts16,
  output logic o_mf_start,
  output logic o_ebit_valid,
  output logic [1:0] o_ebits
);
  import e1ras_pkg::*;
  initial begin
    o_fas = '0;
    o_nfas = '0;
    o_ts16 = '0;
    o_mf_start = 1'b0;
    o_ebit_valid = 1'b0;
    o_ebits = 2'h0;
  end
  // Kind 0 FAS, 1 NFAS, 2 TS16, 3 e-bits, other multiframe start
  task automatic send(input int kind, input logic [7:0] w);
    @(posedge i_core_clk);
    case (kind)
      0: o_fas <= '{1'b1, w};
      1: o_nfas <= '{1'b1, w};
      2: o_ts16 <= '{1'b1, w};
      3: begin
        o_ebit_valid <= 1'b1;
        o_ebits <= w[1:0];
      end
      default: o_mf_start <= 1'b1;
    endcase
    @(posedge i_core_clk);
    // Released data flips so a stale value is never taken for a capture
    o_fas <= '{1'b0, ~o_fas.word};
    o_nfas <= '{1'b0, ~o_nfas.word};
    o_ts16 <= '{1'b0, ~o_ts16.word};
    o_ebits <= ~o_ebits;
    o_ebit_valid <= 1'b0;
    o_mf_start <= 1'b0;
  endtask
endmodule

// >>> tb_e1ras_top.sv
// Self-checking testbench for the E1 receive alignment status bank
`timescale 1ns/1ps
module tb_e1ras_top;
  import e1ras_pkg::*;
  // Short millisecond keeps a full second near 20k cycles
  localparam int unsigned MS = 20;
  logic i_core_clk;
  logic i_arst_n;
  e1ras_bus_req_t bus;
  e1ras_align_t align;
  e1ras_rx_word_t fas;
  e1ras_rx_word_t nfas;
  e1ras_rx_word_t ts16;
  logic mf_start;
  logic ebit_valid;
  logic [1:0] ebits;
  logic [7:0] rd_data;
  logic persist;
  logic reframe;
  logic interwork;
  int n_fail;
  int n_checks;
  e1ras_top #(.MS_CYCLES(MS)) u_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_bus(bus),
    .o_rd_data(rd_data), .i_align(align), .i_crc_mf_start(mf_start), .i_ebit_valid(ebit_valid),
    .i_ebits(ebits), .i_fas(fas), .i_nfas(nfas), .i_ts16(ts16), .o_alignment_loss_persistence(persist),
    .o_checksum_reframe_flag(reframe), .o_checksum_interworking(interwork));
  e1ras_line_model u_line (.i_core_clk(i_core_clk), .o_fas(fas), .o_nfas(nfas), .o_ts16(ts16),
    .o_mf_start(mf_start), .o_ebit_valid(ebit_valid), .o_ebits(ebits));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_words();
    logic [7:0] d;
    align.signalling_multiframe_loss <= 1'b0;
    u_line.send(0, 8'h9b);
    u_line.send(1, 8'h5a);
    u_line.send(2, 8'h0d);
    u_line.send(3, 8'h02);
    // Writes must not disturb captured words
    wr(ADDR_ALIGN_WORD, 8'h64);
    wr(ADDR_SYNC_STATUS, 8'h00);
    rd(ADDR_ALIGN_WORD, d);
    chk("fas_intl", {7'h00, d[7]}, 8'h01);
    chk("fas_pattern", {1'b0, d[6:0]}, 8'h1b);
    rd(ADDR_NON_ALIGN_WORD, d);
    chk("nfas_intl", {7'h00, d[7]}, 8'h00);
    chk("nfas_type", {7'h00, d[6]}, 8'h01);
    chk("nfas_alarm", {7'h00, d[5]}, 8'h00);
    chk("nfas_national", {3'h0, d[4:0]}, 8'h1a);
    rd(ADDR_TS16_WORD, d);
    chk("ts16_nibble", {4'h0, d[7:4]}, 8'h00);
    chk("ts16_spare_y", {4'h0, d[3:0]}, 8'h0d);
    rd(ADDR_SYNC_STATUS, d);
    chk("sync_word", d, 8'hb3);
    rd(8'h15, d);
    chk("unmapped", d, 8'h00);
  endtask
  task automatic t_timers();
    logic [7:0] d;
    logic [7:0] p;
    int n[8];
    int both;
    @(posedge i_core_clk);
    align.frame_loss <= 1'b0;
    rd(ADDR_TIMER_STATUS, p);
    for (int i = 0; i < 1000; i++) begin
      repeat (MS - 2) @(posedge i_core_clk);
      rd(ADDR_TIMER_STATUS, d);
      // Interval bits are counted high, the rest by changes
      for (int b = 0; b < 8; b++) n[b] += (b == 5 || b == 4) ? int'(d[b] === 1'b1) : int'(d[b] !== p[b]);
      both += int'(d[7] !== p[7] && d[6] !== p[6]);
      if (i == 6) chk("persist_hold", {7'h00, persist}, 8'h01);
      if (i == 11) chk("persist_end", {7'h00, persist}, 8'h00);
      if (i == 20) chk("reframe_set", {7'h00, reframe}, 8'h01);
      p = d;
    end
    chk("half_toggles", 8'(n[7]), 8'h02);
    chk("one_toggles", 8'(n[6]), 8'h01);
    chk("in_step", 8'(both), 8'h01);
    chk("crc_int_high", 8'(n[5]), 8'h08);
    chk("eb_int_high", 8'(n[4]), 8'h08);
    chk("long_toggles", 8'(n[3]), 8'h01);
    chk("short_toggles", {7'h00, n[2] >= 49 && n[2] <= 50}, 8'h01);
    chk("checksum_alignment_indicator_toggles", {7'h00, n[1] >= 499 && n[1] <= 501}, 8'h01);
    chk("unused_bit", 8'(n[0]), 8'h00);
    chk("iwk_after", {7'h00, interwork}, 8'h00);
  endtask
  task automatic t_align();
    logic [7:0] d;
    logic [7:0] p;
    @(posedge i_core_clk);
    align.checksum_multiframe_loss <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    rd(ADDR_SYNC_STATUS, d);
    chk("aligned_sync", d & 8'h25, 8'h01);
    rd(ADDR_TIMER_STATUS, p);
    for (int k = 0; k < 3; k++) begin
      u_line.send(4, 8'h00);
      rd(ADDR_TIMER_STATUS, d);
      chk("checksum_alignment_indicator_mf", d & 8'h02, ~p & 8'h02);
      p = d;
    end
    // Without multiframe starts the indicator must rest
    repeat (5 * MS) @(posedge i_core_clk);
    rd(ADDR_TIMER_STATUS, d);
    chk("checksum_alignment_indicator_rest", d & 8'h02, p & 8'h02);
  endtask
  initial begin
    bus = '0;
    align = '1;
    i_arst_n = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_words();
    t_timers();
    t_align();
    complete_run();
  end
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule
